// ===== core/tob_ctrl.sv
// Purpose: Per-tile fuse store, security word, access gating and boot sequence
// Assumes: 10 MHz mclk, synchronous reset, ce freezes all state except the two synchronisers
// Notes:   Debug requests, debug pin and mode pins are synchronised here
`timescale 1ns/10ps
`include "tob_defs.svh"
module tob_ctrl #(
	parameter int          SRAM_WORDS  = 65536,
	parameter int          OTP_ROWS    = `TOB_OTP_SECTORS * `TOB_OTP_SECT_ROWS,
	parameter bit          FIRST_TILE  = 1'b1,
	parameter logic [15:0] SILICON_REV = 16'h0001
) (
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	input  wire logic               ce,
	input  wire logic [1:0]         boot_mode_pin,
	input  wire logic               dbg_req_pin,
	input  wire logic               dbg_access_req,
	input  wire logic               dbg_otp_req,
	input  wire logic               link_access_req,
	input  tob_pkg::tob_prog_t      prog,
	input  tob_pkg::tob_mreq_t      mreq,
	input  wire logic               sec_wr,
	input  wire logic [31:0]        sec_wdata,
	input  tob_pkg::tob_tok_t       ch_in,
	input  wire logic               ch_in_valid,
	output logic                    ch_in_ready,
	output tob_pkg::tob_tok_t       ch_out,
	output logic [31:0]             ch_out_dest,
	output logic                    ch_out_valid,
	input  wire logic               ch_out_ready,
	output logic                    chanend0_alloc,
	output logic [31:0]             mem_rdata,
	output logic                    mem_rvalid,
	output logic [31:0]             otp_rdata,
	output logic                    prog_done,
	output logic                    prog_refused,
	output logic [31:0]             tile_protection_config,
	output logic [31:0]             jtag_user_id_word,
	output logic                    sec_loaded,
	output logic                    dbg_grant,
	output logic                    dbg_otp_grant,
	output logic                    link_grant,
	output logic                    dbg_pin_grant,
	output logic                    redundant_rows_en,
	output logic                    boot_go,
	output tob_pkg::tob_src_t       boot_src,
	output logic [31:0]             boot_addr
);
	localparam int AW = $clog2(SRAM_WORDS);
	localparam int OW = $clog2(OTP_ROWS);

	// ==========================================================
	// Storage: own fuse store and security fuse word per tile
	// Fuse store and fuse word survive reset; unprogrammed fuses read zero
	logic [31:0] otp_mem [OTP_ROWS] = '{default: 32'h0};
	logic [31:0] sram    [SRAM_WORDS];
	logic [31:0] sec_fuse = `TOB_SEC_RESET;
	logic [31:0] sec;

	tob_pkg::tob_state_t state;
	tob_pkg::tob_state_t next_state;
	logic [OW:0]         copy_ptr;
	logic [AW-1:0]       img_ptr;
	logic [31:0]         ack_dest;

	// ==========================================================
	// Synchronisers for pins and the debug clock domain
	logic [1:0] mode_s;
	logic [3:0] req_s;

	tob_sync #(.W(2)) u_sync_mode (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.d       (boot_mode_pin),
		.q       (mode_s)
	);

	tob_sync #(.W(4)) u_sync_req (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.d       ({dbg_req_pin, dbg_access_req, dbg_otp_req, link_access_req}),
		.q       (req_s)
	);

	// ==========================================================
	// Security decode
	wire loaded       = (state == tob_pkg::ST_SELECT) || (state == tob_pkg::ST_CH_ACK) ||
	                    (state == tob_pkg::ST_CH_IMG) || (state == tob_pkg::ST_CH_END) ||
	                    (state == tob_pkg::ST_RUN);
	wire no_dbg       = sec[`TOB_SEC_NO_DBG];
	wire no_link      = sec[`TOB_SEC_NO_LINK];
	wire otp_boot     = sec[`TOB_SEC_OTP_BOOT];
	wire master_lock  = sec[`TOB_SEC_MASTER_LOCK];
	wire no_dbg_otp   = sec[`TOB_SEC_NO_DBG_OTP];
	wire no_dbg_pin   = sec[`TOB_SEC_NO_DBG_PIN];
	wire sec_wr_lock  = sec[`TOB_SEC_WR_LOCK];

	// ==========================================================
	// Programming port decode
	wire        p_write  = prog.en && prog.ctl[`TOB_PCTL_WRITE];
	wire        p_secw   = prog.ctl[`TOB_PCTL_SEC_WORD];
	wire [1:0]  p_sector = prog.addr[OW-1:OW-2];
	wire        p_in_rng = ({16'h0, prog.addr} < OTP_ROWS);
	wire        p_slock  = sec[`TOB_SEC_LOCK_LO + {30'h0, p_sector}];
	wire        p_dbg_no = prog.from_dbg && no_dbg_otp;
	wire        p_refuse = !loaded || master_lock || p_dbg_no ||
	                       (p_secw ? sec_wr_lock : (p_slock || !p_in_rng));
	wire        p_ok     = p_write && !p_refuse;
	wire        p_rd_ok  = prog.en && !prog.ctl[`TOB_PCTL_WRITE] && loaded &&
	                       !p_dbg_no && p_in_rng;

	// ==========================================================
	// Memory request decode, lanes by size and low address
	wire [AW-1:0] m_idx  = mreq.addr[AW+1:2];
	wire [1:0]    m_lane = mreq.addr[1:0];
	wire [3:0]    m_be   = (mreq.size == `TOB_SZ_BYTE) ? (4'h1 << m_lane) :
	                       (mreq.size == `TOB_SZ_HALF) ? (m_lane[1] ? 4'hc : 4'h3) :
	                       4'hf;
	wire [31:0]   m_wsh  = (mreq.size == `TOB_SZ_BYTE) ? {4{mreq.wdata[7:0]}} :
	                       (mreq.size == `TOB_SZ_HALF) ? {2{mreq.wdata[15:0]}} :
	                       mreq.wdata;
	wire          m_go   = mreq.en && (state == tob_pkg::ST_RUN);
	wire [4:0]    m_shft = {m_lane, 3'h0};

	// ==========================================================
	// Channel boot decode
	wire tok_take  = ch_in_valid && ch_in_ready;
	wire tok_end   = tok_take && ch_in.ctl;
	wire tok_word  = tok_take && !ch_in.ctl;
	wire copy_last = (copy_ptr == OTP_ROWS[OW:0] - 1'b1);
	wire ack_sent  = !ch_out_valid || ch_out_ready;

	// ==========================================================
	// Boot sequencer
	always_comb begin
		next_state = state;
		case (state)
			tob_pkg::ST_IDLE: begin
				next_state = tob_pkg::ST_LOADSEC;
			end
			tob_pkg::ST_LOADSEC: begin
				next_state = tob_pkg::ST_COPY;
			end
			tob_pkg::ST_COPY: begin
				if (copy_last) begin
					next_state = tob_pkg::ST_SELECT;
				end
			end
			tob_pkg::ST_SELECT: begin
				if (!otp_boot && mode_s == `TOB_MODE_CHANNEL) begin
					next_state = tob_pkg::ST_CH_ACK;
				end else begin
					next_state = tob_pkg::ST_RUN;
				end
			end
			tob_pkg::ST_CH_ACK: begin
				if (tok_word) begin
					next_state = tob_pkg::ST_CH_IMG;
				end
			end
			tob_pkg::ST_CH_IMG: begin
				if (tok_end) begin
					next_state = tob_pkg::ST_CH_END;
				end
			end
			tob_pkg::ST_CH_END: begin
				if (ack_sent) begin
					next_state = tob_pkg::ST_RUN;
				end
			end
			tob_pkg::ST_RUN: begin
				next_state = tob_pkg::ST_RUN;
			end
			default: begin
				next_state = tob_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state    <= tob_pkg::ST_IDLE;
			copy_ptr <= '0;
			img_ptr  <= '0;
			ack_dest <= `TOB_NULL_CHANEND;
			sec      <= `TOB_SEC_RESET;
		end else if (ce) begin
			state <= next_state;
			if (state == tob_pkg::ST_LOADSEC) begin
				sec <= sec_fuse;
			end else if (loaded && sec_wr && !sec_wr_lock) begin
				sec[`TOB_SEC_USER_HI:`TOB_SEC_USER_LO] <=
					sec_wdata[`TOB_SEC_USER_HI:`TOB_SEC_USER_LO];
				sec[`TOB_SEC_WR_LOCK] <= sec_wdata[`TOB_SEC_WR_LOCK];
			end
			if (state == tob_pkg::ST_COPY) begin
				copy_ptr <= copy_ptr + 1'b1;
			end
			if (state == tob_pkg::ST_COPY && copy_last) begin
				img_ptr <= '0;
			end else if (state == tob_pkg::ST_CH_IMG && tok_word) begin
				img_ptr <= img_ptr + 1'b1;
			end
			if (state == tob_pkg::ST_CH_ACK && tok_word) begin
				ack_dest <= ch_in.data;
			end
		end
	end

	// ==========================================================
	// Fuse store: programming only ever sets bits
	always_ff @(posedge mclk) begin
		if (ce && p_ok && !p_secw) begin
			otp_mem[prog.addr[OW-1:0]] <= otp_mem[prog.addr[OW-1:0]] | prog.data;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prog_done    <= 1'b0;
			prog_refused <= 1'b0;
			otp_rdata    <= '0;
		end else if (ce) begin
			prog_done    <= p_ok;
			prog_refused <= p_write && p_refuse;
			otp_rdata    <= p_rd_ok ? otp_mem[prog.addr[OW-1:0]] : 32'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (ce && p_ok && p_secw) begin
			sec_fuse <= sec_fuse | prog.data;
		end
	end

	// ==========================================================
	// Memory: loader writes during boot, core port afterwards
	always_ff @(posedge mclk) begin
		if (ce) begin
			if (state == tob_pkg::ST_COPY && copy_ptr < SRAM_WORDS) begin
				sram[AW'(copy_ptr)] <= otp_mem[copy_ptr[OW-1:0]];
			end else if (state == tob_pkg::ST_CH_IMG && tok_word) begin
				sram[img_ptr] <= ch_in.data;
			end else if (m_go && mreq.we) begin
				for (int b = 0; b < 4; b++) begin
					if (m_be[b]) begin
						sram[m_idx][8*b +: 8] <= m_wsh[8*b +: 8];
					end
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mem_rdata  <= '0;
			mem_rvalid <= 1'b0;
		end else if (ce) begin
			mem_rvalid <= m_go && !mreq.we;
			mem_rdata  <= (m_go && !mreq.we) ? (sram[m_idx] >> m_shft) : 32'h0;
		end
	end

	// ==========================================================
	// Channel handshake and boot outputs
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ch_in_ready    <= 1'b0;
			ch_out         <= '0;
			ch_out_dest    <= '0;
			ch_out_valid   <= 1'b0;
			chanend0_alloc <= 1'b0;
			boot_go        <= 1'b0;
			boot_src       <= tob_pkg::SRC_NONE;
			boot_addr      <= '0;
		end else if (ce) begin
			ch_in_ready <= (next_state == tob_pkg::ST_CH_ACK) ||
			               (next_state == tob_pkg::ST_CH_IMG);
			chanend0_alloc <= (next_state == tob_pkg::ST_CH_ACK) ||
			                  (next_state == tob_pkg::ST_CH_IMG) ||
			                  (next_state == tob_pkg::ST_CH_END);
			if (state == tob_pkg::ST_CH_IMG && tok_end &&
			    ack_dest != `TOB_NULL_CHANEND) begin
				ch_out_valid <= 1'b1;
				ch_out       <= '{ctl: 1'b1, data: 32'h0};
				ch_out_dest  <= ack_dest;
			end else if (ch_out_ready) begin
				ch_out_valid <= 1'b0;
			end
			boot_go <= (state != tob_pkg::ST_RUN) && (next_state == tob_pkg::ST_RUN);
			if (state == tob_pkg::ST_SELECT) begin
				boot_src  <= otp_boot ? tob_pkg::SRC_OTP :
				             (mode_s == `TOB_MODE_CHANNEL) ? tob_pkg::SRC_CHANNEL :
				             tob_pkg::SRC_EXT;
				boot_addr <= '0;
			end
		end
	end

	// ==========================================================
	// Access gating and visible words
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sec_loaded             <= 1'b0;
			dbg_grant              <= 1'b0;
			dbg_otp_grant          <= 1'b0;
			link_grant             <= 1'b0;
			dbg_pin_grant          <= 1'b0;
			redundant_rows_en      <= 1'b0;
			tile_protection_config <= '0;
			jtag_user_id_word      <= '0;
		end else if (ce) begin
			sec_loaded        <= loaded;
			dbg_grant         <= loaded && req_s[2] && !no_dbg;
			dbg_otp_grant     <= loaded && req_s[1] && !no_dbg && !no_dbg_otp;
			link_grant        <= loaded && req_s[0] && !no_link;
			dbg_pin_grant     <= loaded && req_s[3] && !no_dbg_pin;
			redundant_rows_en <= loaded && sec[`TOB_SEC_REDUNDANT];
			tile_protection_config <= loaded ? sec : 32'h0;
			jtag_user_id_word <= {(FIRST_TILE && loaded) ?
			                      sec[`TOB_SEC_UID_HI:`TOB_SEC_UID_LO] : 10'h0,
			                      6'h0, SILICON_REV};
		end
	end
endmodule

// ===== core/tob_defs.svh
// Purpose: Constants for the tile protection and boot control block
// Assumes: One clock, synchronous active-high reset
// Notes:   Included by the control module and by the bench
`ifndef TOB_DEFS_SVH
`define TOB_DEFS_SVH

// ==========================================================
// Security word fields
`define TOB_SEC_NO_DBG      0
`define TOB_SEC_NO_LINK     1
`define TOB_SEC_OTP_BOOT    5
`define TOB_SEC_REDUNDANT   7
`define TOB_SEC_LOCK_LO     8
`define TOB_SEC_MASTER_LOCK 12
`define TOB_SEC_NO_DBG_OTP  13
`define TOB_SEC_NO_DBG_PIN  14
`define TOB_SEC_USER_HI     21
`define TOB_SEC_USER_LO     15
`define TOB_SEC_UID_HI      31
`define TOB_SEC_UID_LO      22
`define TOB_SEC_WR_LOCK     31
`define TOB_SEC_RESET       32'h0000_0000

// ==========================================================
// Fuse store geometry
`define TOB_OTP_SECTORS     4
`define TOB_OTP_SECT_ROWS   512
`define TOB_OTP_ROW_BITS    32

// ==========================================================
// Programming control port bits
`define TOB_PCTL_WRITE      0
`define TOB_PCTL_SEC_WORD   1

// ==========================================================
// Channel boot
`define TOB_NULL_CHANEND    32'h0000_ff02
`define TOB_MODE_CHANNEL    2'h2

// ==========================================================
// Memory access sizes
`define TOB_SZ_BYTE         2'h0
`define TOB_SZ_HALF         2'h1
`define TOB_SZ_WORD         2'h2

`endif

// ===== core/tob_pkg.sv
// Purpose: Types for the tile protection and boot control block
// Assumes: tob_defs.svh holds the numbers
// Notes:   No imports are used by clients
package tob_pkg;

	// ==========================================================
	// Boot sequencer states, Gray coded along the channel boot path
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_LOADSEC = 3'h1,
		ST_COPY    = 3'h3,
		ST_SELECT  = 3'h2,
		ST_CH_ACK  = 3'h6,
		ST_CH_IMG  = 3'h7,
		ST_CH_END  = 3'h5,
		ST_RUN     = 3'h4
	} tob_state_t;

	typedef enum logic [1:0] {
		SRC_NONE    = 2'h0,
		SRC_OTP     = 2'h1,
		SRC_CHANNEL = 2'h2,
		SRC_EXT     = 2'h3
	} tob_src_t;

	// ==========================================================
	// Channel token and memory request carriers
	typedef struct packed {
		logic        ctl;
		logic [31:0] data;
	} tob_tok_t;

	typedef struct packed {
		logic        en;
		logic        we;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} tob_mreq_t;

	typedef struct packed {
		logic        en;
		logic        from_dbg;
		logic [15:0] addr;
		logic [31:0] data;
		logic [15:0] ctl;
	} tob_prog_t;

endpackage

// ===== core/tob_sync.sv
// Purpose: Two-stage synchroniser for inputs from outside the clock domain
// Assumes: Destination clock mclk
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
module tob_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ===== test/tob_ctrl_checker.sv
// Purpose: Port assertions for tob_ctrl
// Assumes: ce held high, FIRST_TILE set
// Notes:   Bound below the module
`timescale 1ns/10ps
module tob_ctrl_checker (
	input wire logic         mclk,
	input wire logic         sys_rst,
	input wire logic         dbg_access_req,
	input wire logic         dbg_otp_req,
	input wire logic         link_access_req,
	input tob_pkg::tob_prog_t prog,
	input wire logic [31:0]  otp_rdata,
	input wire logic         prog_refused,
	input wire logic [31:0]  tile_protection_config,
	input wire logic [31:0]  jtag_user_id_word,
	input wire logic         sec_loaded,
	input wire logic         dbg_grant,
	input wire logic         dbg_otp_grant,
	input wire logic         link_grant,
	input wire logic         dbg_pin_grant,
	input wire logic         redundant_rows_en,
	input tob_pkg::tob_tok_t ch_out,
	input wire logic [31:0]  ch_out_dest,
	input wire logic         ch_out_valid,
	input wire logic         ch_out_ready,
	input wire logic         boot_go,
	input tob_pkg::tob_src_t boot_src,
	input wire logic [31:0]  boot_addr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire [31:0] cfg = tile_protection_config;
	wire        wr  = sec_loaded && prog.en && prog.ctl[0];
	logic [2:0] ld_hist;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ld_hist <= '0;
		end else begin
			ld_hist <= {ld_hist[1:0], sec_loaded};
		end
	end
	wire        ld3 = sec_loaded && ld_hist[2];
	// ====================
	// Gating
	property p_gate;
		!sec_loaded |-> !(dbg_grant || dbg_otp_grant || link_grant || dbg_pin_grant || boot_go);
	endproperty
	a_gate: assert property (p_gate) else $error("grant before load");
	property p_dbg;
		ld3 && $past(dbg_access_req, 3) |-> dbg_grant == !cfg[0];
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug grant wrong");
	property p_link;
		ld3 && $past(link_access_req, 3) |-> link_grant == !cfg[1];
	endproperty
	a_link: assert property (p_link) else $error("link grant wrong");
	property p_otpg;
		ld3 && $past(dbg_otp_req, 3) |-> dbg_otp_grant == !(cfg[0] || cfg[13]);
	endproperty
	a_otpg: assert property (p_otpg) else $error("debug fuse grant wrong");
	property p_pin;
		sec_loaded && cfg[14] |-> !dbg_pin_grant;
	endproperty
	a_pin: assert property (p_pin) else $error("pin granted");
	property p_red;
		sec_loaded |-> redundant_rows_en == cfg[7];
	endproperty
	a_red: assert property (p_red) else $error("redundant rows wrong");
	// ====================
	// Programming
	property p_sect;
		wr && !prog.ctl[1] && cfg[4'd8 + prog.addr[10:9]] |=> prog_refused;
	endproperty
	a_sect: assert property (p_sect) else $error("locked sector written");
	property p_mast;
		wr && cfg[12] |=> prog_refused;
	endproperty
	a_mast: assert property (p_mast) else $error("master lock ignored");
	property p_dbgrd;
		sec_loaded && prog.en && prog.from_dbg && !prog.ctl[0] && cfg[13] |=> otp_rdata == 0;
	endproperty
	a_dbgrd: assert property (p_dbgrd) else $error("debug fuse read");
	property p_wlock;
		sec_loaded && $past(sec_loaded) && cfg[31] |=> $stable(cfg);
	endproperty
	a_wlock: assert property (p_wlock) else $error("locked word changed");
	property p_uid;
		sec_loaded |-> jtag_user_id_word[31:22] == cfg[31:22];
	endproperty
	a_uid: assert property (p_uid) else $error("user id wrong");
	// ====================
	// Boot
	sequence s_wait;
		ch_out_valid && !ch_out_ready;
	endsequence
	sequence s_held;
		ch_out_valid && ch_out.ctl && ch_out.data == 0 && $stable(ch_out_dest);
	endsequence
	sequence s_jump;
		##[1:3] (boot_go && boot_src == tob_pkg::SRC_CHANNEL);
	endsequence
	property p_hold;
		s_wait |=> s_held;
	endproperty
	a_hold: assert property (p_hold) else $error("end reply dropped");
	property p_jump;
		ch_out_valid && ch_out_ready |-> s_jump;
	endproperty
	a_jump: assert property (p_jump) else $error("no jump after reply");
	property p_sec;
		boot_go && cfg[5] |-> boot_src == tob_pkg::SRC_OTP && boot_addr == 0;
	endproperty
	a_sec: assert property (p_sec) else $error("secure boot wrong");
endmodule
bind tob_ctrl tob_ctrl_checker u_chk (.mclk, .sys_rst, .dbg_access_req, .dbg_otp_req,
	.link_access_req, .prog, .otp_rdata, .prog_refused, .tile_protection_config,
	.jtag_user_id_word, .sec_loaded, .dbg_grant, .dbg_otp_grant, .link_grant,
	.dbg_pin_grant, .redundant_rows_en, .ch_out, .ch_out_dest, .ch_out_valid,
	.ch_out_ready, .boot_go, .boot_src, .boot_addr);

// ===== test/tob_host.sv
// Purpose: Host tile booting the block over the channel
// Assumes: Bench queues tokens in q
// Notes:   Stalls on a fixed pattern both ways
`timescale 1ns/10ps
module tob_host (
	input  wire logic         mclk,
	input  wire logic         ch_in_ready,
	output tob_pkg::tob_tok_t ch_in,
	output logic              ch_in_valid,
	input  tob_pkg::tob_tok_t ch_out,
	input  wire logic [31:0]  ch_out_dest,
	input  wire logic         ch_out_valid,
	output logic              ch_out_ready
);
	tob_pkg::tob_tok_t q[$];
	tob_pkg::tob_tok_t got;
	logic [31:0]       got_dest;
	logic              took;
	int                n_got = 0;
	int                t = 0;
	initial begin
		ch_in = '0;
		ch_in_valid = 1'b0;
		ch_out_ready = 1'b0;
	end
	// ====================
	// Ack word, image, END, each held until taken
	always @(posedge mclk) begin
		took = ch_in_valid && ch_in_ready;
		if (took)
			void'(q.pop_front());
		if (ch_out_valid && ch_out_ready) begin
			got = ch_out;
			got_dest = ch_out_dest;
			n_got++;
		end
		#1;
		t++;
		ch_out_ready = t % 4 != 1;
		if (!ch_in_valid || took) begin
			ch_in_valid = q.size() > 0 && t % 3 != 0;
			ch_in = ch_in_valid ? q[0] : '{1'b0, ~ch_in.data};
		end
	end
endmodule

// ===== test/test_tob_ctrl.sv
// Purpose: Self-checking bench for tob_ctrl
// Assumes: Default fuse geometry, first tile
// Notes:   Three power-ups: blank, locked, master locked
`timescale 1ns/10ps
`include "tob_defs.svh"
module test_tob_ctrl;
	logic               mclk = 1'b0;
	logic               sys_rst = 1'b1;
	logic [1:0]         mode = `TOB_MODE_CHANNEL;
	logic               req = 1'b1;
	logic               sec_wr = 1'b0;
	logic [31:0]        sec_wdata = '0;
	tob_pkg::tob_prog_t prog = '0;
	tob_pkg::tob_mreq_t mreq = '0;
	tob_pkg::tob_tok_t  ch_in, ch_out;
	tob_pkg::tob_src_t  boot_src;
	logic               ch_in_valid, ch_in_ready, ch_out_valid, ch_out_ready;
	logic               chanend0_alloc, mem_rvalid, prog_done, prog_refused, sec_loaded;
	logic               dbg_grant, dbg_otp_grant, link_grant, dbg_pin_grant;
	logic               redundant_rows_en, boot_go, rv;
	logic [31:0]        ch_out_dest, mem_rdata, otp_rdata, boot_addr, rd;
	logic [31:0]        tile_protection_config, jtag_user_id_word;
	logic [31:0]        seed = 32'h0000ad60;
	logic [31:0]        s, r, r2, w, ack;
	logic [31:0]        img[3];
	int                 mismatches = 0;
	int                 checks = 0;
	int                 cyc = 0;

	tob_ctrl dut (.mclk, .sys_rst, .ce(1'b1), .boot_mode_pin(mode), .dbg_req_pin(req),
		.dbg_access_req(req), .dbg_otp_req(req), .link_access_req(req), .prog, .mreq,
		.sec_wr, .sec_wdata, .ch_in, .ch_in_valid, .ch_in_ready, .ch_out, .ch_out_dest,
		.ch_out_valid, .ch_out_ready, .chanend0_alloc, .mem_rdata, .mem_rvalid, .otp_rdata,
		.prog_done, .prog_refused, .tile_protection_config, .jtag_user_id_word,
		.sec_loaded, .dbg_grant, .dbg_otp_grant, .link_grant, .dbg_pin_grant,
		.redundant_rows_en, .boot_go, .boot_src, .boot_addr);
	tob_host host (.mclk, .ch_in_ready, .ch_in, .ch_in_valid, .ch_out, .ch_out_dest,
		.ch_out_valid, .ch_out_ready);

	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			conclude();
		end
	end
	// ====================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] sw_merge(input logic [31:0] f, v);
		return {v[31], f[30:22], v[21:15], f[14:0]};
	endfunction
	task automatic conclude();
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic restart(input logic [1:0] m);
		sys_rst = 1'b1;
		mode = m;
		tick(2);
		sys_rst = 1'b0;
		tick(1);
		chk(sec_loaded, 0);
		chk(dbg_grant, 0);
		for (int i = 0; i < 3000 && sec_loaded !== 1'b1; i++)
			tick(1);
		tick(4);
	endtask
	// Programming agent op; checks done or refused on writes
	task automatic op(input logic dbg, input logic [15:0] ctl, a, input logic [31:0] d,
		input logic ok);
		prog = '{1'b1, dbg, a, d, ctl};
		tick(1);
		prog.en = 1'b0;
		rd = otp_rdata;
		if (ctl[0]) begin
			chk(prog_done, ok);
			chk(prog_refused, !ok);
		end
		tick(1);
	endtask
	task automatic mem(input logic we, input logic [1:0] sz, input logic [31:0] a, d);
		mreq = '{1'b1, we, sz, a, d};
		tick(1);
		mreq.en = 1'b0;
		rd = mem_rdata;
		rv = mem_rvalid;
		tick(1);
	endtask
	task automatic swr(input logic [31:0] d);
		sec_wr = 1'b1;
		sec_wdata = d;
		tick(1);
		sec_wr = 1'b0;
		tick(3);
	endtask
	// ====================
	// Main sequence
	initial begin
		restart(`TOB_MODE_CHANNEL);
		chk(chanend0_alloc, 1);
		chk(dbg_grant, 1);
		chk(link_grant, 1);
		chk(dbg_pin_grant, 1);
		chk(jtag_user_id_word[31:22], 0);
		req = 1'b0;
		tick(4);
		chk(dbg_grant, 0);
		chk(link_grant, 0);
		chk(dbg_pin_grant, 0);
		req = 1'b1;
		ack = rnd();
		host.q.push_back('{1'b0, ack});
		foreach (img[i]) begin
			img[i] = rnd();
			host.q.push_back('{1'b0, img[i]});
		end
		host.q.push_back('{1'b1, 32'h0});
		for (int i = 0; i < 300 && boot_go !== 1'b1; i++)
			tick(1);
		chk(boot_src, tob_pkg::SRC_CHANNEL);
		chk(host.n_got, 1);
		chk(host.got.ctl, 1);
		chk(host.got_dest, ack);
		tick(2);
		chk(chanend0_alloc, 0);
		mem(0, `TOB_SZ_WORD, 0, 0);
		chk(rv, 1);
		chk(rd, img[0]);
		w = rnd();
		mem(1, `TOB_SZ_BYTE, 9, {4{w[7:0]}});
		mem(1, `TOB_SZ_HALF, 10, {2{w[15:0]}});
		mem(0, `TOB_SZ_WORD, 8, 0);
		chk(rd, {w[15:0], w[7:0], img[2][7:0]});
		mem(0, `TOB_SZ_HALF, 10, 0);
		chk(rd[15:0], w[15:0]);
		mem(0, `TOB_SZ_BYTE, 9, 0);
		chk(rd[7:0], w[7:0]);
		r = rnd();
		r2 = rnd();
		op(0, 16'h1, 16'h0201, r, 1);
		op(0, 16'h1, 16'h0201, r2, 1);
		op(1, 16'h0, 16'h0201, 0, 0);
		chk(rd, r | r2);
		op(0, 16'h1, 16'h0800, r, 0);
		w = rnd();
		s = {1'b0, w[30:22], 7'h00, 15'h61a3};
		op(0, 16'h3, 16'h0, s, 1);
		restart(2'h0);
		chk(tile_protection_config, s);
		chk(jtag_user_id_word[31:22], s[31:22]);
		chk(dbg_grant, 0);
		chk(link_grant, 0);
		chk(dbg_otp_grant, 0);
		chk(dbg_pin_grant, 0);
		chk(redundant_rows_en, 1);
		chk(boot_src, tob_pkg::SRC_OTP);
		chk(boot_addr, 0);
		mem(0, `TOB_SZ_WORD, 32'h804, 0);
		chk(rd, r | r2);
		op(0, 16'h1, 16'h0003, r, 0);
		op(0, 16'h1, 16'h0203, r, 1);
		op(1, 16'h0, 16'h0201, 0, 0);
		chk(rd, 0);
		op(0, 16'h3, 16'h0, 32'h1000, 1);
		w = rnd() | 32'h8000_0000;
		swr(w);
		chk(tile_protection_config, sw_merge(s, w));
		swr(~w);
		chk(tile_protection_config, sw_merge(s, w));
		op(0, 16'h3, 16'h0, 32'h1, 0);
		restart(2'h0);
		chk(tile_protection_config, s | 32'h1000);
		op(0, 16'h1, 16'h0205, r, 0);
		op(0, 16'h3, 16'h0, 32'h2, 0);
		conclude();
	end
endmodule
